/* hdl/lde_pkg.sv */
// Shared constants and instruction codes for the ladder edge/bit logic
package lde_pkg;

    localparam int PT_W      = 6;
    localparam int PT_N      = 64;
    localparam int IN_N      = 16;
    localparam int WORD_W    = 16;
    localparam int WADDR_W   = 4;
    localparam int WORD_N    = 16;
    localparam int BIT_W     = 4;
    localparam int SLOT_W    = 4;
    localparam int SLOT_N    = 16;

    // Retentive range of points
    localparam logic [PT_W-1:0] RET_LO = 6'h20;
    localparam logic [PT_W-1:0] RET_HI = 6'h3f;

    localparam logic              BIT_RST  = 1'b0;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [PT_N-1:0]   IMG_RST  = 64'h0000_0000_0000_0000;

    typedef enum logic [3:0] {
        LDE_OP_LOAD,
        LDE_OP_OR,
        LDE_OP_AND,
        LDE_OP_NOT,
        LDE_OP_OUT,
        LDE_OP_OUT_BIT,
        LDE_OP_PULSE,
        LDE_OP_RISE_START,
        LDE_OP_FALL_START,
        LDE_OP_RISE_PAR,
        LDE_OP_FALL_PAR,
        LDE_OP_RISE_SER,
        LDE_OP_FALL_SER,
        LDE_OP_SET,
        LDE_OP_RST
    } lde_op_e;

endpackage

/* hdl/lde_edge_slots.sv */
// Per-instruction previous-scan state for edge contacts and pulse outputs
`timescale 1ns/1ps
module lde_edge_slots
    import lde_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [SLOT_W-1:0] slot,
    input  wire logic              sample_we,
    input  wire logic              sample,
    input  wire logic              commit,
    output logic                   prev
);

    logic [SLOT_N-1:0] sample_r;
    logic [SLOT_N-1:0] prev_r;

    assign prev = prev_r[slot];

    genvar g;
    generate
        for (g = 0; g < SLOT_N; g++) begin : g_slot
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    sample_r[g] <= BIT_RST;
                end else if (sample_we && slot == SLOT_W'(g)) begin
                    sample_r[g] <= sample;
                end
            end

            // Copy taken only at scan end
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    prev_r[g] <= BIT_RST;
                end else if (commit) begin
                    prev_r[g] <= sample_r[g];
                end
            end
        end
    endgenerate

endmodule // lde_edge_slots

/* hdl/lde_rung_engine.sv */
// Rung evaluation engine: bit outputs, inversion, one-shots, edges, set
`timescale 1ns/1ps
//
// Functional notes
// - Bit output writes rung status into selected bit 0..15 of a word.
// - Several bit outputs on one bit: last in program order wins.
// - Inversion replaces rung status with its complement.
// - Pulse output is on exactly one scan per rung off-to-on change.
// - Rising start contact begins rung, closed one scan after point rises.
// - Rising start on retentive point also closes on program-to-run.
// - Falling start contact begins rung, closed one scan after point falls.
// - Parallel rising contact ORs a one-scan closure on each rise.
// - Parallel falling contact ORs a one-scan closure on each fall.
// - Series rising contact ANDs a one-scan closure on each rise.
// - Series falling contact ANDs a one-scan closure on each fall.
// - Set turns on point or range; stays on until reset clears it, input points 0..15 only until the pins reload at scan end.
module lde_rung_engine
    import lde_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               run_mode,
    input  wire logic               scan_end,
    input  wire logic               instr_valid,
    input  wire lde_op_e            instr_op,
    input  wire logic [PT_W-1:0]    instr_pt,
    input  wire logic [PT_W-1:0]    instr_pt_end,
    input  wire logic [WADDR_W-1:0] instr_word,
    input  wire logic [BIT_W-1:0]   instr_bit,
    input  wire logic [SLOT_W-1:0]  instr_slot,
    input  wire logic [IN_N-1:0]    in_image,
    input  wire logic [WADDR_W-1:0] word_rd_addr,
    output logic [PT_N-1:0]         out_image,
    output logic [WORD_W-1:0]       word_rd_data,
    output logic                    rung_state,
    output logic                    first_scan
);

    logic [PT_N-1:0]   points_r;
    logic [WORD_W-1:0] words_r [WORD_N];
    logic              acc_r;
    logic              acc_nxt;
    logic              run_d_r;
    logic              first_scan_r;
    logic [PT_N-1:0]   out_image_r;
    logic [WORD_W-1:0] word_rd_data_r;

    logic              exec;
    logic              cur_pt;
    logic              prev_bit;
    logic              rise;
    logic              fall;
    logic              start_rise;
    logic              retentive;
    logic              sample_we;
    logic              sample;
    logic              edge_op;
    logic              wr_out;
    logic              wr_pulse;
    logic              wr_set;
    logic              wr_clr;
    logic              wr_bit;
    logic              pulse_val;

    // Instructions only run in run mode and never on the scan-end step
    assign exec   = instr_valid && run_mode && !scan_end;
    assign cur_pt = points_r[instr_pt];
    assign retentive = (instr_pt >= RET_LO) && (instr_pt <= RET_HI);

    // Edge terms of the contact, against the same slot's last scan
    always_comb begin
        rise       = cur_pt && !prev_bit;
        fall       = !cur_pt && prev_bit;
        start_rise = rise || (first_scan_r && retentive);
        pulse_val  = acc_r && !prev_bit;
    end

    always_comb begin
        case (instr_op)
            LDE_OP_RISE_START,
            LDE_OP_FALL_START,
            LDE_OP_RISE_PAR,
            LDE_OP_FALL_PAR,
            LDE_OP_RISE_SER,
            LDE_OP_FALL_SER: edge_op = 1'b1;
            default:         edge_op = 1'b0;
        endcase
    end

    // Edge contacts remember the point, pulse outputs remember the rung
    always_comb begin
        sample_we = exec && (edge_op || instr_op == LDE_OP_PULSE);
        if (instr_op == LDE_OP_PULSE) begin
            sample = acc_r;
        end else begin
            sample = cur_pt;
        end
    end

    // Point and word writes asked for by the current instruction
    always_comb begin
        wr_out   = 1'b0;
        wr_pulse = 1'b0;
        wr_set   = 1'b0;
        wr_clr   = 1'b0;
        wr_bit   = 1'b0;
        case (instr_op)
            LDE_OP_OUT: begin
                wr_out = exec;
            end
            LDE_OP_PULSE: begin
                wr_pulse = exec;
            end
            LDE_OP_SET: begin
                wr_set = exec && acc_r;
            end
            LDE_OP_RST: begin
                wr_clr = exec && acc_r;
            end
            LDE_OP_OUT_BIT: begin
                wr_bit = exec;
            end
            default: begin
                wr_out = 1'b0;
            end
        endcase
    end

    lde_edge_slots u_slots (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .slot      (instr_slot),
        .sample_we (sample_we),
        .sample    (sample),
        .commit    (scan_end),
        .prev      (prev_bit)
    );

    // Rung accumulator
    always_comb begin
        acc_nxt = acc_r;
        case (instr_op)
            LDE_OP_LOAD: begin
                acc_nxt = cur_pt;
            end
            LDE_OP_OR: begin
                acc_nxt = acc_r | cur_pt;
            end
            LDE_OP_AND: begin
                acc_nxt = acc_r & cur_pt;
            end
            LDE_OP_NOT: begin
                acc_nxt = !acc_r;
            end
            LDE_OP_RISE_START: begin
                acc_nxt = start_rise;
            end
            LDE_OP_FALL_START: begin
                acc_nxt = fall;
            end
            LDE_OP_RISE_PAR: begin
                acc_nxt = acc_r | rise;
            end
            LDE_OP_FALL_PAR: begin
                acc_nxt = acc_r | fall;
            end
            LDE_OP_RISE_SER: begin
                acc_nxt = acc_r & rise;
            end
            LDE_OP_FALL_SER: begin
                acc_nxt = acc_r & fall;
            end
            default: begin
                acc_nxt = acc_r;
            end
        endcase
    end

    // Accumulator holds across idle and scan-end cycles
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_r <= BIT_RST;
        end else if (exec) begin
            acc_r <= acc_nxt;
        end
    end

    // Program-to-run detection; set wins over the scan-end clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_d_r <= BIT_RST;
        end else begin
            run_d_r <= run_mode;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_scan_r <= BIT_RST;
        end else if (run_mode && !run_d_r) begin
            first_scan_r <= 1'b1;
        end else if (scan_end || !run_mode) begin
            first_scan_r <= 1'b0;
        end
    end

    // Point image, one flop per point; set and clear act only on a true rung
    genvar p;
    generate
        for (p = 0; p < PT_N; p++) begin : g_pt
            logic hit;
            logic in_range;
            logic wr_en;
            logic wr_val;

            assign hit      = (instr_pt == PT_W'(p));
            assign in_range = (PT_W'(p) >= instr_pt)
                              && (PT_W'(p) <= instr_pt_end);

            always_comb begin
                wr_en  = 1'b0;
                wr_val = 1'b0;
                if (hit && wr_out) begin
                    wr_en  = 1'b1;
                    wr_val = acc_r;
                end else if (hit && wr_pulse) begin
                    wr_en  = 1'b1;
                    wr_val = pulse_val;
                end else if (in_range && wr_set) begin
                    wr_en  = 1'b1;
                    wr_val = 1'b1;
                end else if (in_range && wr_clr) begin
                    wr_en  = 1'b1;
                    wr_val = 1'b0;
                end
            end

            if (p < IN_N) begin : g_in
                // Input points follow the pins, taken once per scan
                always_ff @(posedge ref_clk or posedge rst) begin
                    if (rst) begin
                        points_r[p] <= BIT_RST;
                    end else if (scan_end) begin
                        points_r[p] <= in_image[p];
                    end else if (wr_en) begin
                        points_r[p] <= wr_val;
                    end
                end
            end else begin : g_int
                always_ff @(posedge ref_clk or posedge rst) begin
                    if (rst) begin
                        points_r[p] <= BIT_RST;
                    end else if (wr_en) begin
                        points_r[p] <= wr_val;
                    end
                end
            end
        end
    endgenerate

    // Word memory; later writes in program order overwrite earlier ones
    genvar w;
    generate
        for (w = 0; w < WORD_N; w++) begin : g_word
            logic sel;

            assign sel = wr_bit && (instr_word == WADDR_W'(w));

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    words_r[w] <= WORD_RST;
                end else if (sel) begin
                    words_r[w][instr_bit] <= acc_r;
                end
            end
        end
    endgenerate

    // Registered read port; a write shows one cycle after it lands
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_rd_data_r <= WORD_RST;
        end else begin
            word_rd_data_r <= words_r[word_rd_addr];
        end
    end

    // Output image refreshed once per scan
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_image_r <= IMG_RST;
        end else if (scan_end) begin
            out_image_r <= points_r;
        end
    end

    assign out_image    = out_image_r;
    assign word_rd_data = word_rd_data_r;
    assign rung_state   = acc_r;
    assign first_scan   = first_scan_r;

endmodule // lde_rung_engine

/* tb/lde_rung_checker_assertions.sv */
// Port-level checker for the rung engine
`timescale 1ns/1ps
module lde_rung_checker
    import lde_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               rst,
    input wire logic               run_mode,
    input wire logic               scan_end,
    input wire logic               instr_valid,
    input wire lde_op_e            instr_op,
    input wire logic [WADDR_W-1:0] instr_word,
    input wire logic [BIT_W-1:0]   instr_bit,
    input wire logic [WADDR_W-1:0] word_rd_addr,
    input wire logic [PT_N-1:0]    out_image,
    input wire logic [WORD_W-1:0]  word_rd_data,
    input wire logic               rung_state,
    input wire logic               first_scan
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic tk;
    assign tk = instr_valid && run_mode && !scan_end;
    a_not_invert: assert property (
        tk && instr_op == LDE_OP_NOT |=> rung_state == !$past(rung_state))
        else $error("inversion result wrong");
    a_ser_open: assert property (
        tk && !rung_state && instr_op inside {LDE_OP_RISE_SER, LDE_OP_FALL_SER}
        |=> !rung_state) else $error("series edge closed an open rung");
    a_par_closed: assert property (
        tk && rung_state && instr_op inside {LDE_OP_RISE_PAR, LDE_OP_FALL_PAR}
        |=> rung_state) else $error("parallel edge opened a closed rung");
    a_bit_write: assert property (
        tk && instr_op == LDE_OP_OUT_BIT && instr_word == word_rd_addr
        ##1 !instr_valid && $stable(word_rd_addr) ##1 $stable(word_rd_addr)
        |-> word_rd_data[$past(instr_bit, 2)] == $past(rung_state, 2))
        else $error("bit of word not written");
    a_run_first: assert property (
        $rose(run_mode) |=> first_scan) else $error("first scan missing");
    a_first_clear: assert property (
        first_scan && scan_end && !$rose(run_mode) |=> !first_scan)
        else $error("first scan not cleared");
    a_image_hold: assert property (
        !scan_end |=> $stable(out_image)) else $error("image moved mid scan");
    a_idle_rung: assert property (
        !tk |=> $stable(rung_state)) else $error("rung moved without work");
    c_not: cover property (tk && instr_op == LDE_OP_NOT);
    c_bit: cover property (tk && instr_op == LDE_OP_OUT_BIT);
    c_run: cover property ($rose(run_mode));
endmodule // lde_rung_checker

bind lde_rung_engine lde_rung_checker chk_u (.ref_clk(ref_clk), .rst(rst),
    .run_mode(run_mode), .scan_end(scan_end), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_word(instr_word), .instr_bit(instr_bit),
    .word_rd_addr(word_rd_addr), .out_image(out_image),
    .word_rd_data(word_rd_data), .rung_state(rung_state),
    .first_scan(first_scan));

/* tb/ladder_edge_bit_logic_bench.sv */
// Self-checking bench for the rung engine
`timescale 1ns/1ps
module ladder_edge_bit_logic_bench
    import lde_pkg::*;
;
    logic            ref_clk = 1'b0, rst = 1'b1, run_mode = 1'b1;
    logic            scan_end = 1'b0, instr_valid = 1'b0;
    lde_op_e         instr_op = LDE_OP_LOAD;
    logic [PT_W-1:0] instr_pt = 6'h00, instr_pt_end = 6'h00;
    logic [3:0]      instr_word = 4'h0, instr_bit = 4'h0;
    logic [3:0]      instr_slot = 4'h0, word_rd_addr = 4'h3;
    logic [15:0]     in_image = 16'h0001, word_rd_data;
    logic [63:0]     out_image;
    logic            rung_state, first_scan;
    int              n_fail = 0, n_checks = 0;

    always #25 ref_clk = ~ref_clk;

    lde_rung_engine dut_u (.ref_clk(ref_clk), .rst(rst), .run_mode(run_mode),
        .scan_end(scan_end), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_pt(instr_pt), .instr_pt_end(instr_pt_end),
        .instr_word(instr_word), .instr_bit(instr_bit),
        .instr_slot(instr_slot), .in_image(in_image),
        .word_rd_addr(word_rd_addr), .out_image(out_image),
        .word_rd_data(word_rd_data), .rung_state(rung_state),
        .first_scan(first_scan));

    task complete_run;
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One instruction per cycle, no gap between calls
    task ex(input lde_op_e op, input logic [5:0] pt, input logic [5:0] pe = 0,
            input logic [3:0] sl = 0, input logic [3:0] w = 0,
            input logic [3:0] b = 0);
        @(negedge ref_clk);
        instr_valid = 1'b1;
        instr_op = op;
        instr_pt = pt;
        instr_pt_end = pe;
        instr_slot = sl;
        instr_word = w;
        instr_bit = b;
    endtask

    task scan;
        @(negedge ref_clk);
        instr_valid = 1'b0;
        scan_end = 1'b1;
        @(negedge ref_clk);
        scan_end = 1'b0;
    endtask

    task t_bits;
        ex(LDE_OP_LOAD, 6'h00);
        ex(LDE_OP_OUT_BIT, 6'h00, 0, 0, 4'h3, 4'hf);
        ex(LDE_OP_OUT_BIT, 6'h00, 0, 0, 4'h3, 4'h0);
        ex(LDE_OP_LOAD, 6'h01);
        ex(LDE_OP_OUT_BIT, 6'h00, 0, 0, 4'h3, 4'hf);
        scan;
        chk("word3", 16'h0001, word_rd_data);
    endtask

    task t_not;
        ex(LDE_OP_LOAD, 6'h01);
        ex(LDE_OP_NOT, 6'h00);
        ex(LDE_OP_OUT, 6'h28);
        chk("rung", 16'h0001, 16'(rung_state));
        ex(LDE_OP_LOAD, 6'h01);
        ex(LDE_OP_OR, 6'h00);
        ex(LDE_OP_AND, 6'h00);
        ex(LDE_OP_OUT, 6'h30);
        ex(LDE_OP_AND, 6'h01);
        ex(LDE_OP_OUT, 6'h31);
        scan;
        chk("not", 16'h0001, 16'(out_image[40]));
        chk("or_and", 16'h0001, 16'(out_image[49:48]));
    endtask

    task prog_edges;
        ex(LDE_OP_RISE_START, 6'h02, 0, 0);
        ex(LDE_OP_OUT, 6'h29);
        ex(LDE_OP_FALL_START, 6'h02, 0, 1);
        ex(LDE_OP_OUT, 6'h2a);
        ex(LDE_OP_LOAD, 6'h01);
        ex(LDE_OP_RISE_PAR, 6'h02, 0, 2);
        ex(LDE_OP_OUT, 6'h2b);
        ex(LDE_OP_LOAD, 6'h01);
        ex(LDE_OP_FALL_PAR, 6'h02, 0, 3);
        ex(LDE_OP_OUT, 6'h2c);
        ex(LDE_OP_LOAD, 6'h00);
        ex(LDE_OP_RISE_SER, 6'h02, 0, 4);
        ex(LDE_OP_OUT, 6'h2d);
        ex(LDE_OP_LOAD, 6'h00);
        ex(LDE_OP_FALL_SER, 6'h02, 0, 5);
        ex(LDE_OP_OUT, 6'h2e);
        ex(LDE_OP_LOAD, 6'h02);
        ex(LDE_OP_PULSE, 6'h2f, 0, 6);
    endtask

    task t_edges;
        logic [5:0] v;
        logic p, r, f;
        v = 6'b000110;
        p = 1'b0;
        for (int i = 0; i < 5; i++) begin
            prog_edges;
            in_image = {13'h0000, v[i+1], 2'b01};
            scan;
            r = v[i] & ~p;
            f = ~v[i] & p;
            chk("rise", 16'({4{r}}),
                16'({out_image[47], out_image[45], out_image[43],
                     out_image[41]}));
            chk("fall", 16'({3{f}}),
                16'({out_image[46], out_image[44], out_image[42]}));
            p = v[i];
        end
    endtask

    task t_set;
        ex(LDE_OP_LOAD, 6'h00);
        ex(LDE_OP_RISE_PAR, 6'h02, 0, 9);
        ex(LDE_OP_SET, 6'h34, 6'h36);
        scan;
        chk("set", 16'h0007, 16'(out_image[55:52]));
        ex(LDE_OP_LOAD, 6'h01);
        ex(LDE_OP_FALL_SER, 6'h02, 0, 10);
        ex(LDE_OP_RST, 6'h34, 6'h36);
        scan;
        chk("hold", 16'h0007, 16'(out_image[55:52]));
        ex(LDE_OP_LOAD, 6'h00);
        ex(LDE_OP_RST, 6'h34, 6'h36);
        scan;
        chk("clear", 16'h0000, 16'(out_image[55:52]));
    endtask

    task prog_ret;
        ex(LDE_OP_RISE_START, 6'h20, 0, 7);
        ex(LDE_OP_OUT, 6'h38);
        ex(LDE_OP_RISE_START, 6'h00, 0, 8);
        ex(LDE_OP_OUT, 6'h39);
        scan;
    endtask

    task t_retain;
        ex(LDE_OP_LOAD, 6'h00);
        ex(LDE_OP_SET, 6'h20, 6'h20);
        scan;
        prog_ret;
        prog_ret;
        chk("steady", 16'h0000, 16'(out_image[57:56]));
        run_mode = 1'b0;
        repeat (3) @(negedge ref_clk);
        run_mode = 1'b1;
        @(negedge ref_clk);
        chk("first", 16'h0001, 16'(first_scan));
        prog_ret;
        chk("retain", 16'h0001, 16'(out_image[57:56]));
        prog_ret;
        chk("after", 16'h0000, 16'(out_image[57:56]));
    endtask

    initial begin
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        scan;
        t_bits;
        t_not;
        t_edges;
        t_set;
        t_retain;
        complete_run;
    end

    initial begin
        #100000;
        n_fail++;
        complete_run;
    end
endmodule // ladder_edge_bit_logic_bench
